// File: hdl/srld_pkg.sv
/*
 * Constants for the shift, rotate and conjunction decoder: opcode bytes,
 * field positions, operation codes and the core clock count of every form.
 * Assumes nothing of its surroundings; shared by the decoder and the cycle timer.
 */
package srld_pkg;

    // Opcode bytes and masks; size bit cleared in all but 0F, A5 and AD
    localparam logic [7:0] OP_SHIFT_BY_ONE   = 8'hD0;
    localparam logic [7:0] OP_SHIFT_BY_CREG  = 8'hD2;
    localparam logic [7:0] OP_SHIFT_BY_IMM   = 8'hC0;
    localparam logic [7:0] OP_TWO_BYTE       = 8'h0F;
    localparam logic [7:0] OP2_DBL_LEFT_IMM  = 8'hA4;
    localparam logic [7:0] OP2_DBL_LEFT_CREG = 8'hA5;
    localparam logic [7:0] OP2_DBL_RIGHT_IMM = 8'hAC;
    localparam logic [7:0] OP2_DBL_RIGHT_CRG = 8'hAD;
    localparam logic [7:0] OP_AND_REG_FORM   = 8'h20;
    localparam logic [7:0] OP_AND_REG_MASK   = 8'hFC;
    localparam logic [7:0] OP_IMM_GROUP      = 8'h80;
    localparam logic [7:0] OP_AND_ACC        = 8'h24;
    localparam logic [7:0] OP_UNARY_GROUP    = 8'hF6;
    localparam logic [7:0] OP_TEST_ACC       = 8'hA8;
    localparam logic [7:0] OP_SIZE_MASK      = 8'hFE;

    // Field positions
    localparam int unsigned SIZE_BIT = 0;
    localparam int unsigned DIR_BIT  = 1;
    localparam int unsigned MOD_HI   = 7;
    localparam int unsigned MOD_LO   = 6;
    localparam int unsigned SEL_HI   = 5;
    localparam int unsigned SEL_LO   = 3;

    localparam logic [1:0] MOD_REGISTER   = 2'h3;
    localparam logic [2:0] SEL_AND_IMM    = 3'h4;
    localparam logic [2:0] SEL_TEST_IMM   = 3'h0;

    // Operation-select field of the shift group
    localparam logic [2:0] SEL_ROTATE_LEFT          = 3'h0;
    localparam logic [2:0] SEL_ROTATE_RIGHT         = 3'h1;
    localparam logic [2:0] SEL_ROTATE_LEFT_CARRY    = 3'h2;
    localparam logic [2:0] SEL_ROTATE_RIGHT_CARRY   = 3'h3;
    localparam logic [2:0] SEL_SHIFT_LEFT           = 3'h4;
    localparam logic [2:0] SEL_LOGICAL_SHIFT_RIGHT  = 3'h5;

    typedef enum logic [3:0] {
        ALU_ROTATE_LEFT             = 4'h0,
        ALU_ROTATE_RIGHT            = 4'h1,
        ALU_ROTATE_LEFT_VIA_CARRY   = 4'h2,
        ALU_ROTATE_RIGHT_VIA_CARRY  = 4'h3,
        ALU_SHIFT_LEFT              = 4'h4,
        ALU_LOGICAL_SHIFT_RIGHT     = 4'h5,
        ALU_DOUBLE_WIDTH_LEFT_SHIFT = 4'h6,
        ALU_DOUBLE_WIDTH_RIGHT_SHIFT= 4'h7,
        ALU_AND                     = 4'h8,
        ALU_TEST                    = 4'h9,
        ALU_NONE                    = 4'hF
    } srld_alu_op_e;

    typedef enum logic [1:0] {
        CNT_NONE                = 2'h0,
        CNT_ONE                 = 2'h1,
        CNT_COUNT_BYTE_REGISTER = 2'h2,
        CNT_IMM8                = 2'h3
    } srld_count_src_e;

    // Clock counts, register operand / memory operand
    localparam logic [3:0] CLK_SHIFT_REG       = 4'h3;
    localparam logic [3:0] CLK_SHIFT_MEM       = 4'h7;
    localparam logic [3:0] CLK_CARRY_ROT_REG   = 4'h9;
    localparam logic [3:0] CLK_CARRY_ROT_MEM   = 4'hA;
    localparam logic [3:0] CLK_DBL_SHIFT_REG   = 4'h3;
    localparam logic [3:0] CLK_DBL_SHIFT_MEM   = 4'h7;
    localparam logic [3:0] CLK_AND_REG_REG     = 4'h2;
    localparam logic [3:0] CLK_AND_MEM_TO_REG  = 4'h6;
    localparam logic [3:0] CLK_AND_REG_TO_MEM  = 4'h7;
    localparam logic [3:0] CLK_AND_IMM_REG     = 4'h2;
    localparam logic [3:0] CLK_AND_IMM_MEM     = 4'h7;
    localparam logic [3:0] CLK_AND_ACC         = 4'h2;
    localparam logic [3:0] CLK_TEST_IMM_REG    = 4'h2;
    localparam logic [3:0] CLK_TEST_IMM_MEM    = 4'h5;
    localparam logic [3:0] CLK_TEST_ACC        = 4'h2;

    localparam logic [3:0] CYCLES_ONE          = 4'h1;
    localparam logic [3:0] CYCLES_ZERO         = 4'h0;

endpackage

// File: hdl/srld_tmr_if.sv
/*
 * Link between the decoder and its cycle timer.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface srld_tmr_if;
    logic       start;
    logic [3:0] cycles;
    logic       done;

    modport ctl (output start, output cycles, input done);
    modport tmr (input start, input cycles, output done);
endinterface

`default_nettype wire

// File: hdl/srld_cycle_timer.sv
/*
 * Counts out the clocks an accepted instruction occupies and pulses done
 * in its last clock. Assumes start is a one-cycle pulse, cycles is at least
 * one, and no new start arrives before done.
 */
`timescale 1ns/1ps
`default_nettype none

module srld_cycle_timer (
    input  wire logic core_clk,
    input  wire logic rst,
    srld_tmr_if.tmr   tmr
);

    typedef struct packed {
        logic [3:0] count;
        logic       done;
    } srld_tmr_state_s;

    srld_tmr_state_s q;
    srld_tmr_state_s d;

    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (tmr.start) begin
            d.count = tmr.cycles - srld_pkg::CYCLES_ONE;
            d.done  = (tmr.cycles == srld_pkg::CYCLES_ONE);
        end else if (q.count != srld_pkg::CYCLES_ZERO) begin
            d.count = q.count - srld_pkg::CYCLES_ONE;
            d.done  = (q.count == srld_pkg::CYCLES_ONE);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tmr.done = q.done;

endmodule // srld_cycle_timer

`default_nettype wire

// File: hdl/srld_decode.sv
/*
 * Decoder and sequencer for the shift/rotate, double-width shift,
 * conjunction and flag-only conjunction instructions. Takes the opcode
 * byte(s) and the operand specifier from the decode path, presents the
 * decoded control to the ALU and bus sequencer, and holds off the next
 * instruction until its clock count has elapsed.
 * Assumes the decode path drives all inputs from core_clk logic, supplies
 * the second opcode byte on instr_op1 for two-byte opcodes and the operand
 * specifier on instr_modrm, and handles flagged undefined opcodes itself.
 */
// Summary of operation
// RL1 - Select field picks rotate or shift kind
// RL2 - Count-register form: 3 or 7 clocks
// RL3 - Immediate count form: 3 or 7 clocks
// RL4 - Through-carry rotates: 9 or 10 clocks
// RL5 - Double left shift decode, 3 or 7
// RL6 - Double right shift decode, 3 or 7
// RL7 - Register-form conjunction, direction and size bits
// RL8 - Conjunction memory source 6, memory destination 7
// RL9 - Immediate conjunction group: 2 or 7 clocks
// RL10 - Accumulator immediate conjunction takes 2 clocks
// RL11 - Flag-only conjunction never writes a destination
// RL12 - Immediate flag-only conjunction: 2 or 5 clocks
// RL13 - Accumulator flag-only conjunction takes 2 clocks
// RL14 - Count-of-one form: 3 or 7 clocks
// RL15 - Register figure first, memory second; mode-independent
// RL16 - Double shifts fill from reg; 110/111 undefined
`timescale 1ns/1ps
`default_nettype none

module srld_decode (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       instr_valid,
    input  wire logic [7:0] instr_op0,
    input  wire logic [7:0] instr_op1,
    input  wire logic [7:0] instr_modrm,
    output logic            instr_ready,
    output logic            dec_valid,
    output logic [3:0]      dec_alu_op,
    output logic [1:0]      dec_count_src,
    output logic            dec_wide,
    output logic            dec_dir,
    output logic            dec_mem,
    output logic            dec_write_dest,
    output logic            dec_imm_data,
    output logic            dec_fill_from_reg,
    output logic            dec_undefined,
    output logic            dec_foreign,
    output logic [3:0]      dec_clocks,
    output logic            exec_done
);

    typedef struct packed {
        logic       ready;
        logic       dec_valid;
        logic [3:0] alu_op;
        logic [1:0] count_src;
        logic       wide;
        logic       dir;
        logic       mem;
        logic       write_dest;
        logic       imm_data;
        logic       fill_from_reg;
        logic       undefined;
        logic       foreign;
        logic [3:0] clocks;
        logic       start;
    } srld_state_s;

    srld_state_s q;
    srld_state_s d;

    srld_tmr_if tmr_link ();

    srld_cycle_timer u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .tmr      (tmr_link.tmr)
    );

    logic       is_mem;
    logic [2:0] sel;
    logic [7:0] op0_base;

    assign is_mem   = (instr_modrm[srld_pkg::MOD_HI:srld_pkg::MOD_LO] != srld_pkg::MOD_REGISTER);
    assign sel      = instr_modrm[srld_pkg::SEL_HI:srld_pkg::SEL_LO];
    assign op0_base = instr_op0 & srld_pkg::OP_SIZE_MASK;

    always_comb begin
        d           = q;
        d.dec_valid = 1'b0;
        d.start     = 1'b0;

        if (!q.ready && tmr_link.done) begin
            d.ready = 1'b1;
        end

        if (q.ready && instr_valid) begin
            d.dec_valid     = 1'b1;
            d.alu_op        = srld_pkg::ALU_NONE;
            d.count_src     = srld_pkg::CNT_NONE;
            d.wide          = instr_op0[srld_pkg::SIZE_BIT];
            d.dir           = 1'b0;
            d.mem           = is_mem;
            d.write_dest    = 1'b1;
            d.imm_data      = 1'b0;
            d.fill_from_reg = 1'b0;
            d.undefined     = 1'b0;
            d.foreign       = 1'b0;
            d.clocks        = is_mem ? srld_pkg::CLK_SHIFT_MEM : srld_pkg::CLK_SHIFT_REG; // RL15

            if (op0_base == srld_pkg::OP_SHIFT_BY_ONE ||
                op0_base == srld_pkg::OP_SHIFT_BY_CREG ||
                op0_base == srld_pkg::OP_SHIFT_BY_IMM) begin
                if (op0_base == srld_pkg::OP_SHIFT_BY_ONE) begin
                    d.count_src = srld_pkg::CNT_ONE; // RL14
                end else if (op0_base == srld_pkg::OP_SHIFT_BY_CREG) begin
                    d.count_src = srld_pkg::CNT_COUNT_BYTE_REGISTER; // RL2
                end else begin
                    d.count_src = srld_pkg::CNT_IMM8; // RL3
                end
                unique case (sel)
                    srld_pkg::SEL_ROTATE_LEFT: begin
                        d.alu_op = srld_pkg::ALU_ROTATE_LEFT; // RL1
                    end
                    srld_pkg::SEL_ROTATE_RIGHT: begin
                        d.alu_op = srld_pkg::ALU_ROTATE_RIGHT; // RL1
                    end
                    srld_pkg::SEL_ROTATE_LEFT_CARRY: begin
                        d.alu_op = srld_pkg::ALU_ROTATE_LEFT_VIA_CARRY; // RL1
                    end
                    srld_pkg::SEL_ROTATE_RIGHT_CARRY: begin
                        d.alu_op = srld_pkg::ALU_ROTATE_RIGHT_VIA_CARRY; // RL1
                    end
                    srld_pkg::SEL_SHIFT_LEFT: begin
                        d.alu_op = srld_pkg::ALU_SHIFT_LEFT; // RL1
                    end
                    srld_pkg::SEL_LOGICAL_SHIFT_RIGHT: begin
                        d.alu_op = srld_pkg::ALU_LOGICAL_SHIFT_RIGHT; // RL1
                    end
                    default: begin
                        // Codes 110 and 111 go to the core's invalid-opcode path
                        d.undefined = 1'b1; // RL16
                    end
                endcase
                if (sel == srld_pkg::SEL_ROTATE_LEFT_CARRY ||
                    sel == srld_pkg::SEL_ROTATE_RIGHT_CARRY) begin
                    d.clocks = is_mem ? srld_pkg::CLK_CARRY_ROT_MEM
                                      : srld_pkg::CLK_CARRY_ROT_REG; // RL4
                end
            end else if (instr_op0 == srld_pkg::OP_TWO_BYTE &&
                         (instr_op1 == srld_pkg::OP2_DBL_LEFT_IMM ||
                          instr_op1 == srld_pkg::OP2_DBL_LEFT_CREG ||
                          instr_op1 == srld_pkg::OP2_DBL_RIGHT_IMM ||
                          instr_op1 == srld_pkg::OP2_DBL_RIGHT_CRG)) begin
                // Double shifts have no byte form
                d.wide          = 1'b1;
                d.fill_from_reg = 1'b1; // RL16
                d.clocks        = is_mem ? srld_pkg::CLK_DBL_SHIFT_MEM
                                         : srld_pkg::CLK_DBL_SHIFT_REG; // RL5
                if (instr_op1 == srld_pkg::OP2_DBL_LEFT_IMM ||
                    instr_op1 == srld_pkg::OP2_DBL_LEFT_CREG) begin
                    d.alu_op = srld_pkg::ALU_DOUBLE_WIDTH_LEFT_SHIFT; // RL5
                end else begin
                    d.alu_op = srld_pkg::ALU_DOUBLE_WIDTH_RIGHT_SHIFT; // RL6
                end
                d.count_src = instr_op1[0] ? srld_pkg::CNT_COUNT_BYTE_REGISTER
                                           : srld_pkg::CNT_IMM8; // RL6
            end else if ((instr_op0 & srld_pkg::OP_AND_REG_MASK) ==
                         srld_pkg::OP_AND_REG_FORM) begin
                d.alu_op = srld_pkg::ALU_AND; // RL7
                d.dir    = instr_op0[srld_pkg::DIR_BIT]; // RL7
                if (!is_mem) begin
                    d.clocks = srld_pkg::CLK_AND_REG_REG; // RL7
                end else if (instr_op0[srld_pkg::DIR_BIT]) begin
                    d.clocks = srld_pkg::CLK_AND_MEM_TO_REG; // RL8
                end else begin
                    d.clocks = srld_pkg::CLK_AND_REG_TO_MEM; // RL8
                end
            end else if (op0_base == srld_pkg::OP_IMM_GROUP &&
                         sel == srld_pkg::SEL_AND_IMM) begin
                d.alu_op   = srld_pkg::ALU_AND; // RL9
                d.imm_data = 1'b1;
                d.clocks   = is_mem ? srld_pkg::CLK_AND_IMM_MEM
                                    : srld_pkg::CLK_AND_IMM_REG; // RL9
            end else if (op0_base == srld_pkg::OP_AND_ACC) begin
                d.alu_op   = srld_pkg::ALU_AND;
                d.imm_data = 1'b1;
                d.mem      = 1'b0;
                d.clocks   = srld_pkg::CLK_AND_ACC; // RL10
            end else if (op0_base == srld_pkg::OP_UNARY_GROUP &&
                         sel == srld_pkg::SEL_TEST_IMM) begin
                d.alu_op     = srld_pkg::ALU_TEST;
                d.imm_data   = 1'b1;
                d.write_dest = 1'b0; // RL11
                d.clocks     = is_mem ? srld_pkg::CLK_TEST_IMM_MEM
                                      : srld_pkg::CLK_TEST_IMM_REG; // RL12
            end else if (op0_base == srld_pkg::OP_TEST_ACC) begin
                d.alu_op     = srld_pkg::ALU_TEST;
                d.imm_data   = 1'b1;
                d.mem        = 1'b0;
                d.write_dest = 1'b0; // RL11
                d.clocks     = srld_pkg::CLK_TEST_ACC; // RL13
            end else begin
                // Not an instruction of this group; another decoder owns it
                d.foreign = 1'b1;
            end

            if (d.undefined || d.foreign) begin
                d.write_dest = 1'b0;
                d.clocks     = srld_pkg::CYCLES_ZERO;
            end else begin
                // Busy until the timer has counted the whole clock figure
                d.ready = 1'b0;
                d.start = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            q           <= '0;
            q.ready     <= 1'b1;
            q.alu_op    <= srld_pkg::ALU_NONE;
        end else begin
            q <= d;
        end
    end

    assign tmr_link.start  = q.start;
    assign tmr_link.cycles = q.clocks;

    assign instr_ready       = q.ready;
    assign dec_valid         = q.dec_valid;
    assign dec_alu_op        = q.alu_op;
    assign dec_count_src     = q.count_src;
    assign dec_wide          = q.wide;
    assign dec_dir           = q.dir;
    assign dec_mem           = q.mem;
    assign dec_write_dest    = q.write_dest;
    assign dec_imm_data      = q.imm_data;
    assign dec_fill_from_reg = q.fill_from_reg;
    assign dec_undefined     = q.undefined;
    assign dec_foreign       = q.foreign;
    assign dec_clocks        = q.clocks;
    assign exec_done         = tmr_link.done;

endmodule // srld_decode

`default_nettype wire

// File: tb/srld_decode_asserts.sv
/*
 * Concurrent checks on the srld_decode ports: handshake, clock counts, flags.
 * Assumes it is bound into srld_decode and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module srld_decode_asserts (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       instr_valid,
    input wire logic       instr_ready,
    input wire logic       dec_valid,
    input wire logic [3:0] dec_alu_op,
    input wire logic       dec_mem,
    input wire logic       dec_wide,
    input wire logic       dec_write_dest,
    input wire logic       dec_fill_from_reg,
    input wire logic       dec_undefined,
    input wire logic       dec_foreign,
    input wire logic [3:0] dec_clocks,
    input wire logic       exec_done
);
    // Cycles since the last decode pulse, and the count it announced
    logic [3:0] gap_q;
    logic [3:0] len_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_q <= 4'h0;
            len_q <= 4'h0;
        end else if (dec_valid) begin
            gap_q <= 4'h1;
            len_q <= dec_clocks;
        end else if (gap_q != 4'hF) begin
            gap_q <= gap_q + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_take; instr_valid && instr_ready |=> dec_valid; endproperty
    property p_no_extra; dec_valid |-> $past(instr_valid) && $past(instr_ready); endproperty
    property p_done_exact; exec_done |-> gap_q == len_q && len_q != 4'h0; endproperty
    property p_done_due; gap_q == len_q && len_q != 4'h0 |-> exec_done; endproperty
    property p_ready_back; exec_done |-> !instr_ready ##1 instr_ready; endproperty
    property p_carry;
        dec_valid && (dec_alu_op == 4'h2 || dec_alu_op == 4'h3)
            |-> dec_clocks == (dec_mem ? 4'hA : 4'h9);
    endproperty
    property p_shift;
        dec_valid && (dec_alu_op < 4'h2 || dec_alu_op == 4'h4 || dec_alu_op == 4'h5)
            |-> dec_clocks == (dec_mem ? 4'h7 : 4'h3);
    endproperty
    property p_double;
        dec_valid && (dec_alu_op == 4'h6 || dec_alu_op == 4'h7)
            |-> dec_wide && dec_fill_from_reg && dec_clocks == (dec_mem ? 4'h7 : 4'h3);
    endproperty
    property p_test;
        dec_valid && dec_alu_op == 4'h9
            |-> !dec_write_dest && dec_clocks == (dec_mem ? 4'h5 : 4'h2);
    endproperty
    property p_undef;
        dec_valid && (dec_undefined || dec_foreign)
            |-> dec_clocks == 4'h0 && instr_ready && !dec_write_dest;
    endproperty
    property p_and_reg; dec_valid && dec_alu_op == 4'h8 && !dec_mem |-> dec_clocks == 4'h2; endproperty

    a_take: assert property (p_take) else $error("request taken without decode pulse");
    a_no_extra: assert property (p_no_extra) else $error("decode pulse without request");
    a_done_exact: assert property (p_done_exact) else $error("done at wrong cycle");
    a_done_due: assert property (p_done_due) else $error("done missing when due");
    a_ready_back: assert property (p_ready_back) else $error("ready not back after done");
    a_carry: assert property (p_carry) else $error("carry rotate count wrong");
    a_shift: assert property (p_shift) else $error("shift count wrong");
    a_double: assert property (p_double) else $error("double shift decode wrong");
    a_test: assert property (p_test) else $error("flag-only decode wrong");
    a_undef: assert property (p_undef) else $error("undefined decode wrong");
    a_and_reg: assert property (p_and_reg) else $error("register conjunction count wrong");

    c_carry_mem: cover property (dec_valid && dec_alu_op == 4'h3 && dec_mem);
    c_undef: cover property (dec_valid && dec_undefined);
    c_test_mem: cover property (dec_valid && dec_alu_op == 4'h9 && dec_mem);
endmodule // srld_decode_asserts

bind srld_decode srld_decode_asserts u_chk (
    .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .dec_valid(dec_valid), .dec_alu_op(dec_alu_op), .dec_mem(dec_mem), .dec_wide(dec_wide),
    .dec_write_dest(dec_write_dest), .dec_fill_from_reg(dec_fill_from_reg),
    .dec_undefined(dec_undefined), .dec_foreign(dec_foreign), .dec_clocks(dec_clocks),
    .exec_done(exec_done)
);

`default_nettype wire

// File: tb/testbench.sv
/*
 * Self-checking bench for srld_decode: every instruction form, refusals, reset.
 * Assumes the decoder's hand-over timing; inputs change on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       instr_valid = 1'b0;
    logic [7:0] instr_op0 = 8'h00;
    logic [7:0] instr_op1 = 8'h00;
    logic [7:0] instr_modrm = 8'h00;
    logic       instr_ready, dec_valid, dec_wide, dec_dir, dec_mem, dec_write_dest;
    logic       dec_imm_data, dec_fill_from_reg, dec_undefined, dec_foreign, exec_done;
    logic [3:0] dec_alu_op, dec_clocks;
    logic [1:0] dec_count_src;
    int         miscompares = 0;
    int         compares = 0;

    srld_decode dut (
        .core_clk(core_clk), .rst(rst), .instr_valid(instr_valid), .instr_op0(instr_op0),
        .instr_op1(instr_op1), .instr_modrm(instr_modrm), .instr_ready(instr_ready),
        .dec_valid(dec_valid), .dec_alu_op(dec_alu_op), .dec_count_src(dec_count_src),
        .dec_wide(dec_wide), .dec_dir(dec_dir), .dec_mem(dec_mem),
        .dec_write_dest(dec_write_dest), .dec_imm_data(dec_imm_data),
        .dec_fill_from_reg(dec_fill_from_reg), .dec_undefined(dec_undefined),
        .dec_foreign(dec_foreign), .dec_clocks(dec_clocks), .exec_done(exec_done)
    );

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // One whole instruction; starts and ends at a falling edge with ready high
    task automatic run(input logic [7:0] op0, op1, modrm, alu, cs, clk, mem, wr);
        int k;
        chk(instr_ready, 8'h01);
        instr_valid = 1'b1;
        instr_op0 = op0;
        instr_op1 = op1;
        instr_modrm = modrm;
        @(negedge core_clk);
        instr_valid = 1'b0;
        chk(dec_valid, 8'h01);
        chk(8'(dec_alu_op), alu);
        chk(8'(dec_count_src), cs);
        chk(8'(dec_clocks), clk);
        chk(dec_mem, mem);
        chk(dec_write_dest, wr);
        for (k = 1; k <= clk; k++) begin
            chk(instr_ready, 8'h00);
            @(negedge core_clk);
            chk(exec_done, 8'(k == clk));
        end
        @(negedge core_clk);
        chk(instr_ready, 8'h01);
        chk(exec_done, 8'h00);
    endtask

    task automatic t_shift;
        int s, f, m;
        logic [7:0] op;
        for (s = 0; s < 6; s++) for (f = 0; f < 3; f++) for (m = 0; m < 2; m++) begin
            op = (f == 0) ? 8'hD0 : (f == 1) ? 8'hD2 : 8'hC0;
            run(op | 8'(m), 8'h00, {(m != 0) ? 2'b00 : 2'b11, 3'(s), 3'h1}, 8'(s), 8'(f + 1),
                (s == 2 || s == 3) ? ((m != 0) ? 8'h0A : 8'h09) : ((m != 0) ? 8'h07 : 8'h03),
                8'(m), 8'h01);
        end
        $display("test shift_group done");
    endtask

    task automatic t_double;
        int i, m;
        logic [7:0] codes [4] = '{8'hA4, 8'hA5, 8'hAC, 8'hAD};
        for (i = 0; i < 4; i++) for (m = 0; m < 2; m++) begin
            run(8'h0F, codes[i], (m != 0) ? 8'h16 : 8'hD6, 8'(6 + i / 2), (i % 2 != 0) ? 8'h02 : 8'h03,
                (m != 0) ? 8'h07 : 8'h03, 8'(m), 8'h01);
            chk(dec_wide, 8'h01);
            chk(dec_fill_from_reg, 8'h01);
        end
        $display("test double_shift done");
    endtask

    task automatic t_and;
        int i;
        for (i = 0; i < 4; i++) begin
            run(8'(8'h20 + i), 8'h00, 8'hC1, 8'h08, 8'h00, 8'h02, 8'h00, 8'h01);
            chk(dec_dir, 8'(i / 2));
            chk(dec_wide, 8'(i % 2));
        end
        run(8'h22, 8'h00, 8'h06, 8'h08, 8'h00, 8'h06, 8'h01, 8'h01);
        run(8'h21, 8'h00, 8'h06, 8'h08, 8'h00, 8'h07, 8'h01, 8'h01);
        run(8'h80, 8'h00, 8'hE0, 8'h08, 8'h00, 8'h02, 8'h00, 8'h01);
        chk(dec_imm_data, 8'h01);
        run(8'h81, 8'h00, 8'h26, 8'h08, 8'h00, 8'h07, 8'h01, 8'h01);
        run(8'h25, 8'h00, 8'h00, 8'h08, 8'h00, 8'h02, 8'h00, 8'h01);
        chk(dec_imm_data, 8'h01);
        $display("test conjunction done");
    endtask

    task automatic t_test;
        run(8'hF6, 8'h00, 8'hC0, 8'h09, 8'h00, 8'h02, 8'h00, 8'h00);
        run(8'hF7, 8'h00, 8'h06, 8'h09, 8'h00, 8'h05, 8'h01, 8'h00);
        run(8'hA8, 8'h00, 8'h00, 8'h09, 8'h00, 8'h02, 8'h00, 8'h00);
        $display("test flag_only done");
    endtask

    // Undefined selects and a foreign opcode taken back to back
    task automatic t_undef;
        instr_valid = 1'b1;
        instr_op0 = 8'hD0;
        instr_modrm = 8'hF0;
        @(negedge core_clk);
        instr_op0 = 8'hD1;
        instr_modrm = 8'hF8;
        chk(dec_undefined, 8'h01);
        chk(instr_ready, 8'h01);
        @(negedge core_clk);
        instr_op0 = 8'h80;
        instr_modrm = 8'hC8;
        chk(dec_valid, 8'h01);
        chk(dec_undefined, 8'h01);
        @(negedge core_clk);
        instr_valid = 1'b0;
        chk(dec_foreign, 8'h01);
        chk(8'(dec_clocks), 8'h00);
        repeat (12) begin
            @(negedge core_clk);
            chk(exec_done, 8'h00);
        end
        $display("test undefined done");
    endtask

    // Request held while busy must not be taken
    task automatic t_busy;
        instr_valid = 1'b1;
        instr_op0 = 8'h22;
        instr_modrm = 8'hC0;
        @(negedge core_clk);
        instr_op0 = 8'h90;
        @(negedge core_clk);
        chk(dec_valid, 8'h00);
        @(negedge core_clk);
        chk(exec_done, 8'h01);
        instr_valid = 1'b0;
        @(negedge core_clk);
        chk(dec_valid, 8'h00);
        chk(instr_ready, 8'h01);
        $display("test busy_refusal done");
    endtask

    // Reset in mid-instruction cancels it
    task automatic t_reset;
        instr_valid = 1'b1;
        instr_op0 = 8'hD3;
        instr_modrm = 8'h10;
        @(negedge core_clk);
        instr_valid = 1'b0;
        rst = 1'b1;
        @(negedge core_clk);
        chk(instr_ready, 8'h01);
        chk(8'(dec_alu_op), 8'h0F);
        rst = 1'b0;
        repeat (12) begin
            @(negedge core_clk);
            chk(exec_done, 8'h00);
        end
        $display("test mid_reset done");
    endtask

    initial begin
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        chk(8'(dec_alu_op), 8'h0F);
        t_shift();
        t_double();
        t_and();
        t_test();
        t_undef();
        t_busy();
        t_reset();
        complete_run();
    end

    initial begin
        #20000;
        miscompares++;
        complete_run();
    end
endmodule // testbench

`default_nettype wire
